// *** core/hlis_pkg.sv ***
package hlis_pkg;
	localparam logic [15:0] ADDR_CTRL2_IRQ_ENABLE = 16'h0b17;
	localparam logic [15:0] ADDR_CTRL3_EVENT_STATUS = 16'h0b26;
	localparam int BIT_CHECK_ERR = 2;
	localparam int BIT_ABORT = 1;
	localparam int BIT_IDLE = 0;
	localparam int BIT_MSG_KIND = 7;
	localparam int BIT_TX_START = 6;
	localparam int BIT_RX_START = 5;
	localparam int BIT_TX_END = 4;
	localparam int BIT_RX_END = 3;
	localparam logic [2:0] ENABLE_MASK = 3'h7;
	localparam logic [2:0] ENABLE_RESET = 3'h0;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] IDLE_OCTET = 8'h7e;
	localparam logic [2:0] ABORT_ONES = 3'h7;
	localparam logic [2:0] ONES_PRE_ABORT = 3'h6;
	localparam logic [2:0] ONES_ZERO = 3'h0;
	localparam logic [7:0] SHIFT_RESET = 8'h00;
endpackage : hlis_pkg

// *** core/hlis_line_watch.sv ***
`timescale 1ns/1ns
module hlis_line_watch
	import hlis_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic bitValid,
	input wire logic bitIn,
	output logic abortSeen,
	output logic idleSeen
);
	typedef struct packed {
		logic [7:0] shift;
		logic [2:0] ones;
		logic abortSeen;
		logic idleSeen;
	} hlis_watch_t;
	hlis_watch_t st_reg;
	hlis_watch_t st_next;
	always_comb begin
		st_next = st_reg;
		st_next.abortSeen = 1'b0;
		st_next.idleSeen = 1'b0;
		if (bitValid) begin
			st_next.shift = {st_reg.shift[6:0], bitIn};
			// R4: seven ones abort
			if (!bitIn) begin
				st_next.ones = ONES_ZERO;
			end else if (st_reg.ones == ONES_PRE_ABORT) begin
				st_next.ones = ABORT_ONES;
				st_next.abortSeen = 1'b1;
			end else if (st_reg.ones != ABORT_ONES) begin
				st_next.ones = 3'(st_reg.ones + 3'h1);
			end
			if ({st_reg.shift[6:0], bitIn} == IDLE_OCTET) begin
				st_next.idleSeen = 1'b1;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_reg <= '{SHIFT_RESET, ONES_ZERO, 1'b0, 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end
	assign abortSeen = st_reg.abortSeen;
	assign idleSeen = st_reg.idleSeen;
	// R4: abort after seven ones
	chk_abort_seven: assert property ( // R4
		@(posedge clk) disable iff (sys_rst)
		(bitValid && bitIn && st_reg.ones == ONES_PRE_ABORT) |=> abortSeen)
		else $error("abort not flagged on seventh one");
	cover_abort: cover property (@(posedge clk) abortSeen);
endmodule : hlis_line_watch

// *** core/hlis_irq_status.sv ***
`timescale 1ns/1ns
// Functional notes
// R1: ctrl2 bit2 enables check error irq
// R2: ctrl2 bit1 enables abort irq
// R3: ctrl2 bit0 enables idle flag irq
// R4: abort is seven consecutive ones
// R5: status bit7 gives message kind
// R6: bit6 set on transmit start
// R7: host refills buffer after transmit start
// R8: bit5 set on receive start
// R9: bit4 set on transmit end
// R10: host loads next buffer before end
// R11: bit3 set on receive end/full
// R12: bit2 set on check error
// R13: bit1 set on abort
// R14: bit0 set on idle octet
// R15: host reads idle plus end as done
// R16: flags clear on read, reset zero
// R17: irq while enabled flag set
module hlis_irq_status
	import hlis_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [15:0] hostAddr,
	input wire logic [7:0] hostWrData,
	input wire logic hostWrEn,
	input wire logic hostRdEn,
	output logic [7:0] hostRdData,
	input wire logic ctrl2RxBitValid,
	input wire logic ctrl2RxBit,
	input wire logic ctrl2CheckError,
	input wire logic ctrl3RxBitValid,
	input wire logic ctrl3RxBit,
	input wire logic ctrl3MessageOriented,
	input wire logic ctrl3TxStart,
	input wire logic ctrl3RxStart,
	input wire logic ctrl3TxEnd,
	input wire logic ctrl3RxEnd,
	input wire logic ctrl3RxBufferFull,
	input wire logic ctrl3CheckError,
	output logic irqReq
);
	typedef struct packed {
		logic [2:0] enable;
		logic [2:0] ctrl2Pend;
		logic [7:0] status;
		logic [7:0] rdData;
		logic irq;
	} hlis_state_t;
	hlis_state_t st_reg;
	hlis_state_t st_next;
	logic ctrl2Abort;
	logic ctrl2Idle;
	logic ctrl3Abort;
	logic ctrl3Idle;
	logic [7:0] setEv;
	logic [2:0] ctrl2Ev;
	logic rdStatus;
	logic rdEnable;
	logic wrEnable;

	hlis_line_watch watch2 (
		.clk(clk),
		.sys_rst(sys_rst),
		.bitValid(ctrl2RxBitValid),
		.bitIn(ctrl2RxBit),
		.abortSeen(ctrl2Abort),
		.idleSeen(ctrl2Idle)
	);
	hlis_line_watch watch3 (
		.clk(clk),
		.sys_rst(sys_rst),
		.bitValid(ctrl3RxBitValid),
		.bitIn(ctrl3RxBit),
		.abortSeen(ctrl3Abort),
		.idleSeen(ctrl3Idle)
	);

	always_comb begin
		rdStatus = hostRdEn && hostAddr == ADDR_CTRL3_EVENT_STATUS;
		rdEnable = hostRdEn && hostAddr == ADDR_CTRL2_IRQ_ENABLE;
		wrEnable = hostWrEn && hostAddr == ADDR_CTRL2_IRQ_ENABLE;
		setEv = STATUS_RESET;
		// R6: transmit start
		setEv[BIT_TX_START] = ctrl3TxStart;
		// R8: receive start
		setEv[BIT_RX_START] = ctrl3RxStart;
		// R9: transmit end
		setEv[BIT_TX_END] = ctrl3TxEnd;
		// R11: end or full
		setEv[BIT_RX_END] = ctrl3RxEnd || ctrl3RxBufferFull;
		// R12: check error
		setEv[BIT_CHECK_ERR] = ctrl3CheckError;
		// R13: abort detected
		setEv[BIT_ABORT] = ctrl3Abort;
		// R14: idle octet
		setEv[BIT_IDLE] = ctrl3Idle;
		ctrl2Ev = 3'h0;
		// R1: check error event
		ctrl2Ev[BIT_CHECK_ERR] = ctrl2CheckError;
		// R2: abort event
		ctrl2Ev[BIT_ABORT] = ctrl2Abort;
		// R3: idle octet event
		ctrl2Ev[BIT_IDLE] = ctrl2Idle;
		st_next = st_reg;
		if (wrEnable) begin
			st_next.enable = hostWrData[2:0] & ENABLE_MASK;
		end
		// R16: clear on read, set wins
		if (rdStatus) begin
			st_next.status[6:0] = setEv[6:0];
		end else begin
			st_next.status[6:0] = st_reg.status[6:0] | setEv[6:0];
		end
		// R5: message kind live
		st_next.status[BIT_MSG_KIND] = ctrl3MessageOriented;
		// R1: pending cleared on enable read
		if (rdEnable) begin
			st_next.ctrl2Pend = ctrl2Ev;
		end else begin
			st_next.ctrl2Pend = st_reg.ctrl2Pend | ctrl2Ev;
		end
		if (rdStatus) begin
			st_next.rdData = st_reg.status;
		end else if (rdEnable) begin
			st_next.rdData = {5'h00, st_reg.enable};
		end else begin
			st_next.rdData = 8'h00;
		end
		// R17: irq gated by enables
		st_next.irq = |(st_next.ctrl2Pend & st_next.enable);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_reg <= '{ENABLE_RESET, ENABLE_RESET, STATUS_RESET,
				STATUS_RESET, 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end
	assign hostRdData = st_reg.rdData;
	assign irqReq = st_reg.irq;

	// R17: irq tracks enabled pending
	chk_irq_gate: assert property ( // R17
		@(posedge clk) disable iff (sys_rst)
		irqReq == |(st_reg.ctrl2Pend & st_reg.enable))
		else $error("irq does not match pending and enable");
	// R1: check error raises irq
	chk_check_irq: assert property ( // R1
		@(posedge clk) disable iff (sys_rst)
		(ctrl2CheckError && st_next.enable[BIT_CHECK_ERR]) |=> irqReq)
		else $error("check error irq missing");
	// R2: irq blocked when off
	chk_abort_off: assert property ( // R2
		@(posedge clk) disable iff (sys_rst)
		(st_reg.enable == 3'h0 && !wrEnable) |=> !irqReq)
		else $error("irq with enables off");
	// R2: abort raises irq
	chk_abort_irq: assert property ( // R2
		@(posedge clk) disable iff (sys_rst)
		(ctrl2Abort && st_next.enable[BIT_ABORT]) |=> irqReq)
		else $error("abort irq missing");
	// R3: idle irq enabled
	chk_idle_irq: assert property ( // R3
		@(posedge clk) disable iff (sys_rst)
		(ctrl2Idle && st_next.enable[BIT_IDLE]) |=> irqReq)
		else $error("idle irq missing");
	// R1: enable write lands
	chk_enable_write: assert property ( // R1
		@(posedge clk) disable iff (sys_rst)
		wrEnable |=> st_reg.enable == $past(hostWrData[2:0]))
		else $error("enable write lost");
	// R6: tx start sets flag
	chk_tx_start: assert property ( // R6
		@(posedge clk) disable iff (sys_rst)
		ctrl3TxStart |=> st_reg.status[BIT_TX_START])
		else $error("transmit start flag not set");
	// R8: rx start sets flag
	chk_rx_start: assert property ( // R8
		@(posedge clk) disable iff (sys_rst)
		ctrl3RxStart |=> st_reg.status[BIT_RX_START])
		else $error("receive start flag not set");
	// R9: tx end sets flag
	chk_tx_end: assert property ( // R9
		@(posedge clk) disable iff (sys_rst)
		ctrl3TxEnd |=> st_reg.status[BIT_TX_END])
		else $error("transmit end flag not set");
	// R11: full sets end flag
	chk_rx_end: assert property ( // R11
		@(posedge clk) disable iff (sys_rst)
		(ctrl3RxEnd || ctrl3RxBufferFull) |=> st_reg.status[BIT_RX_END])
		else $error("receive end flag not set");
	// R12: check error sets flag
	chk_check_flag: assert property ( // R12
		@(posedge clk) disable iff (sys_rst)
		ctrl3CheckError |=> st_reg.status[BIT_CHECK_ERR])
		else $error("check error flag not set");
	// R13: abort sets flag
	chk_abort_flag: assert property ( // R13
		@(posedge clk) disable iff (sys_rst)
		ctrl3Abort |=> st_reg.status[BIT_ABORT])
		else $error("abort flag not set");
	// R14: idle octet sets flag
	chk_idle_flag: assert property ( // R14
		@(posedge clk) disable iff (sys_rst)
		ctrl3Idle |=> st_reg.status[BIT_IDLE])
		else $error("idle flag not set");
	// R16: read clears flags
	chk_read_clear: assert property ( // R16
		@(posedge clk) disable iff (sys_rst)
		(rdStatus && setEv == 8'h00) |=> st_reg.status[6:0] == 7'h00)
		else $error("flags not cleared by read");
	// R16: set wins over read
	chk_set_wins: assert property ( // R16
		@(posedge clk) disable iff (sys_rst)
		(rdStatus && setEv[6:0] != 7'h00)
			|=> st_reg.status[6:0] == $past(setEv[6:0]))
		else $error("event lost on read");
	// R16: flags held until read
	chk_flag_hold: assert property ( // R16
		@(posedge clk) disable iff (sys_rst)
		!rdStatus |=> (st_reg.status[6:0] & $past(st_reg.status[6:0]))
			== $past(st_reg.status[6:0]))
		else $error("flag lost without read");
	// R16: read returns old status
	chk_read_data: assert property ( // R16
		@(posedge clk) disable iff (sys_rst)
		rdStatus |=> hostRdData == $past(st_reg.status))
		else $error("status read data wrong");
	// R5: message kind follows input
	chk_msg_kind: assert property ( // R5
		@(posedge clk) disable iff (sys_rst)
		1'b1 |=> st_reg.status[BIT_MSG_KIND] == $past(ctrl3MessageOriented))
		else $error("message kind wrong");
	// R17: irq drops once cleared
	chk_irq_drop: assert property ( // R17
		@(posedge clk) disable iff (sys_rst)
		(rdEnable && ctrl2Ev == 3'h0) |=> !irqReq)
		else $error("irq stays after pending cleared");
	cover_irq: cover property (@(posedge clk) irqReq);
	cover_read: cover property (@(posedge clk) rdStatus && st_reg.status != 8'h00);
	cover_set_clear: cover property (@(posedge clk) rdStatus && setEv != 8'h00);
endmodule : hlis_irq_status

// *** bench/testbench.sv ***
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
	$display("ERROR %0t: got %h want %h", $time, g, e); end end
module testbench;
	import hlis_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic wrEn = 1'b0, rdEn = 1'b0, bv = 1'b0, bb = 1'b0, sel = 1'b0;
	logic c2e = 1'b0, kind = 1'b0, irqReq;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wrData = 8'h00, rdData, rnd = 8'h1f;
	logic [5:0] ev = 6'h00, m;
	int error_cnt = 0, compares = 0, cyc = 0;
	int bitOf[6] = '{BIT_TX_START, BIT_RX_START, BIT_TX_END, BIT_RX_END,
		BIT_RX_END, BIT_CHECK_ERR};
	hlis_irq_status dut (.clk(clk), .sys_rst(sys_rst), .hostAddr(addr),
		.hostWrData(wrData), .hostWrEn(wrEn), .hostRdEn(rdEn),
		.hostRdData(rdData), .ctrl2RxBitValid(bv & ~sel), .ctrl2RxBit(bb),
		.ctrl2CheckError(c2e), .ctrl3RxBitValid(bv & sel), .ctrl3RxBit(bb),
		.ctrl3MessageOriented(kind), .ctrl3TxStart(ev[0]),
		.ctrl3RxStart(ev[1]), .ctrl3TxEnd(ev[2]), .ctrl3RxEnd(ev[3]),
		.ctrl3RxBufferFull(ev[4]), .ctrl3CheckError(ev[5]), .irqReq(irqReq));
	function automatic logic [7:0] nextRnd(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : nextRnd
	function automatic logic [7:0] expStat(input logic k, input logic [5:0] q);
		logic [7:0] r;
		r = 8'h00;
		r[BIT_MSG_KIND] = k;
		for (int i = 0; i < 6; i++) if (q[i]) r[bitOf[i]] = 1'b1;
		return r;
	endfunction : expStat
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wrData = d;
		wrEn = 1'b1;
		@(negedge clk);
		wrEn = 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(negedge clk);
		addr = a;
		rdEn = 1'b1;
		@(negedge clk);
		rdEn = 1'b0;
		`CHK(rdData, e)
	endtask : rd
	task automatic bits(input logic ch, input logic [7:0] v);
		sel = ch;
		for (int i = 7; i >= 0; i--) begin
			@(negedge clk);
			bv = 1'b1;
			bb = v[i];
		end
		@(negedge clk);
		bv = 1'b0;
		repeat (3) @(negedge clk);
	endtask : bits
	task automatic fire(input int j);
		if (j == BIT_CHECK_ERR) begin
			@(negedge clk);
			c2e = 1'b1;
			@(negedge clk);
			c2e = 1'b0;
			repeat (3) @(negedge clk);
		end else bits(1'b0, (j == BIT_ABORT) ? 8'h7f : IDLE_OCTET);
	endtask : fire
	task automatic give_verdict;
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : give_verdict
	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			give_verdict();
		end
	end
	initial begin
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		rd(ADDR_CTRL2_IRQ_ENABLE, 8'h00);
		rd(ADDR_CTRL3_EVENT_STATUS, STATUS_RESET);
		for (int k = 0; k < 18; k++) begin
			rnd = nextRnd(rnd);
			m = (k < 6) ? 6'(1 << k) : rnd[5:0];
			@(negedge clk);
			kind = rnd[7];
			ev = m;
			@(negedge clk);
			ev = 6'h00;
			rd(ADDR_CTRL3_EVENT_STATUS, expStat(kind, m));
			rd(ADDR_CTRL3_EVENT_STATUS, expStat(kind, 6'h00));
		end
		bits(1'b1, IDLE_OCTET);
		rd(ADDR_CTRL3_EVENT_STATUS, expStat(kind, 6'h00) | 8'h01);
		bits(1'b1, 8'h7f);
		rd(ADDR_CTRL3_EVENT_STATUS, expStat(kind, 6'h00) | 8'h02);
		// idle plus end read as done
		bits(1'b1, IDLE_OCTET);
		@(negedge clk);
		ev = 6'h08;
		@(negedge clk);
		ev = 6'h00;
		rd(ADDR_CTRL3_EVENT_STATUS, expStat(kind, 6'h08) | 8'h01);
		@(negedge clk);
		addr = ADDR_CTRL3_EVENT_STATUS;
		rdEn = 1'b1;
		ev = 6'h01;
		@(negedge clk);
		rdEn = 1'b0;
		ev = 6'h00;
		`CHK(rdData, expStat(kind, 6'h00))
		rd(ADDR_CTRL3_EVENT_STATUS, expStat(kind, 6'h01));
		@(negedge clk);
		ev = 6'h04;
		@(negedge clk);
		ev = 6'h00;
		rd(ADDR_CTRL3_EVENT_STATUS, expStat(kind, 6'h04));
		repeat (4) begin
			rnd = nextRnd(rnd);
			wr(ADDR_CTRL2_IRQ_ENABLE, rnd);
			rd(ADDR_CTRL2_IRQ_ENABLE, {5'h00, rnd[2:0]});
		end
		wr(16'h0b18, 8'hff);
		rd(16'h0b18, 8'h00);
		rd(ADDR_CTRL2_IRQ_ENABLE, {5'h00, rnd[2:0]});
		for (int j = 0; j < 3; j++) begin
			wr(ADDR_CTRL2_IRQ_ENABLE, 8'(ENABLE_MASK ^ (3'h1 << j)) | 8'hf8);
			fire(j);
			`CHK(irqReq, 1'b0)
			wr(ADDR_CTRL2_IRQ_ENABLE, 8'(3'h1 << j));
			repeat (2) @(negedge clk);
			`CHK(irqReq, 1'b1)
			rd(ADDR_CTRL2_IRQ_ENABLE, 8'(3'h1 << j));
			repeat (2) @(negedge clk);
			`CHK(irqReq, 1'b0)
		end
		give_verdict();
	end
endmodule : testbench
